// [inc/hpit_map.svh]
// constants and rule overview for the host process interrupt trigger
//
// Overview of operation
// R1 - each qualifying trigger event raises a process interrupt request to the host (code: none is raised while synchronised platform-valid is low)
// R2 - the 32-bit supplementary info word travels with each request
// R3 - with both-edges select low only a rising trigger edge qualifies
// R4 - with both-edges select high every trigger transition qualifies
// R5 - a new request is issued only while none awaits acknowledgement
// R6 - an event during an unacknowledged request sets the error flag instead
// R7 - error flag clears on host acknowledge or while clear-error input is high
// R8 - device never stalls; a pending flag remembers the open request
// R9 - host acknowledges only after its handler routine has finished
// R10 - error flag held high while the platform-valid input is false
// R11 - reset clears previous trigger level, pending flag and error flag
`ifndef HPIT_MAP_SVH
`define HPIT_MAP_SVH

// ------------------------------------------------------------------
// apb register offsets
// ------------------------------------------------------------------
`define HPIT_CTRL_OFS    12'h000
`define HPIT_STAT_OFS    12'h004
`define HPIT_INFO_OFS    12'h008
`define HPIT_CNT_OFS     12'h00C

// ------------------------------------------------------------------
// field positions
// ------------------------------------------------------------------
`define HPIT_CTRL_BOTH   0
`define HPIT_CTRL_CLR    1
`define HPIT_STAT_PEND   0
`define HPIT_STAT_ERR    1
`define HPIT_STAT_PLAT   2

// ------------------------------------------------------------------
// reset values
// ------------------------------------------------------------------
`define HPIT_CTRL_RST    2'h0
`define HPIT_INFO_RST    32'h0000_0000

`endif

// [inc/hpit_pkg.sv]
// types for the host process interrupt trigger
package hpit_pkg;
   typedef logic [31:0] hpit_word_t;
   typedef enum logic [1:0] {
      HPIT_IDLE = 2'b00,
      HPIT_PEND = 2'b01
   } hpit_state_e;
endpackage : hpit_pkg

// [verif/hpit_host.sv]
// host model: acknowledges each request after its handler delay
`timescale 1ns/10ps
module hpit_host (
   input  wire logic       core_clk_i,
   input  wire logic       rst_n_i,
   input  wire logic       irq_i,
   input  wire logic [4:0] lat_i,
   output logic            ack_o
);
   logic [4:0] cnt_ff;
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cnt_ff <= 5'h00;
      end else if (irq_i) begin
         cnt_ff <= lat_i;
      end else if (cnt_ff != 5'h00) begin
         cnt_ff <= cnt_ff - 5'h01;
      end
   end
   assign ack_o = (cnt_ff == 5'h01);
endmodule : hpit_host

// [verif/hpit_properties.sv]
// assertion checker for the process interrupt trigger
`timescale 1ns/10ps
module hpit_properties (
   input wire logic        core_clk_i,
   input wire logic        rst_n_i,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        platform_valid_i,
   input wire logic        host_ack_i,
   input wire logic        host_irq_o,
   input wire logic [31:0] supplementary_info_word_o,
   input wire logic        error_flag_out_o
);
   logic       pend_ff;
   logic       clr_ff;
   logic [4:0] pvh_ff;
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!rst_n_i);
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pend_ff <= 1'b0;
         clr_ff  <= 1'b0;
         pvh_ff  <= 5'h1F;
      end else begin
         pend_ff <= host_irq_o | (pend_ff & ~host_ack_i);
         pvh_ff  <= {pvh_ff[3:0], platform_valid_i};
         if (psel && penable && pwrite && paddr == 12'h000) begin
            clr_ff <= pwdata[1];
         end
      end
   end
   property p_pulse; host_irq_o |=> !host_irq_o; endproperty
   a_pulse: assert property (p_pulse) else $error("request wider than a cycle");
   property p_info; !host_irq_o |-> $stable(supplementary_info_word_o); endproperty
   a_info: assert property (p_info) else $error("info word moved");
   property p_pend; pend_ff |-> !host_irq_o; endproperty
   a_pend: assert property (p_pend) else $error("request while pending");
   property p_rise; $rose(error_flag_out_o) |-> pend_ff || $past(pend_ff) || !(&pvh_ff);
   endproperty
   a_rise: assert property (p_rise) else $error("error set without cause");
   property p_fall; $fell(error_flag_out_o) |-> $past(host_ack_i) || clr_ff || $past(clr_ff)
      || !(&pvh_ff); endproperty
   a_fall: assert property (p_fall) else $error("error cleared without cause");
   property p_clr; clr_ff && (&pvh_ff) |=> !error_flag_out_o; endproperty
   a_clr: assert property (p_clr) else $error("error not held clear");
   property p_plat; pvh_ff == 5'h00 |-> error_flag_out_o; endproperty
   a_plat: assert property (p_plat) else $error("error low on bad platform");
   property p_apb; psel && penable && paddr > 12'h00C |-> pready && pslverr; endproperty
   a_apb: assert property (p_apb) else $error("unmapped access not refused");
endmodule : hpit_properties
bind hpit_top hpit_properties hpit_properties_inst (
   .core_clk_i                (core_clk_i),
   .rst_n_i                   (rst_n_i),
   .psel                      (psel),
   .penable                   (penable),
   .pwrite                    (pwrite),
   .paddr                     (paddr),
   .pwdata                    (pwdata),
   .pready                    (pready),
   .pslverr                   (pslverr),
   .platform_valid_i          (platform_valid_i),
   .host_ack_i                (host_ack_i),
   .host_irq_o                (host_irq_o),
   .supplementary_info_word_o (supplementary_info_word_o),
   .error_flag_out_o          (error_flag_out_o)
);

// [verif/tb_top.sv]
// testbench for the process interrupt trigger
`timescale 1ns/10ps
module tb_top;
   import hpit_pkg::*;
   logic        core_clk_i = 1'b0;
   logic        rst_n_i = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic        trigger_i = 1'b0;
   logic        platform_valid_i = 1'b1;
   logic [4:0]  lat = 5'h02;
   logic [31:0] prdata, q;
   logic        pready, pslverr, e, host_ack_i, host_irq_o, error_flag_out_o;
   hpit_word_t  supplementary_info_word_o, info;
   hpit_word_t  exp_q[$];
   int          num_errors = 0;
   int          checked = 0;
   int          seed = 32'h5B7A8926;
   always #2 core_clk_i = ~core_clk_i;
   hpit_top hpit_top_inst (
      .core_clk_i                (core_clk_i),
      .rst_n_i                   (rst_n_i),
      .psel                      (psel),
      .penable                   (penable),
      .pwrite                    (pwrite),
      .paddr                     (paddr),
      .pwdata                    (pwdata),
      .prdata                    (prdata),
      .pready                    (pready),
      .pslverr                   (pslverr),
      .trigger_i                 (trigger_i),
      .platform_valid_i          (platform_valid_i),
      .host_ack_i                (host_ack_i),
      .host_irq_o                (host_irq_o),
      .supplementary_info_word_o (supplementary_info_word_o),
      .error_flag_out_o          (error_flag_out_o)
   );
   hpit_host hpit_host_inst (
      .core_clk_i (core_clk_i),
      .rst_n_i    (rst_n_i),
      .irq_i      (host_irq_o),
      .lat_i      (lat),
      .ack_o      (host_ack_i)
   );
   task automatic chk(input logic [31:0] g, input logic [31:0] x);
      checked++;
      if (g !== x) begin
         num_errors++;
         $display("MISMATCH %0t got %h exp %h", $time, g, x);
      end
   endtask : chk
   task automatic chk_bit(input logic g, input logic x);
      checked++;
      if (g !== x) begin
         num_errors++;
         $display("MISMATCH %0t got %b exp %b", $time, g, x);
      end
   endtask : chk_bit
   task automatic give_verdict;
      if (num_errors == 0 && checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : give_verdict
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int i;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk_i);
      penable <= 1'b1;
      for (i = 0; i < 16; i++) begin
         @(posedge core_clk_i);
         if (pready === 1'b1) break;
      end
      if (i == 16) begin
         num_errors++;
         give_verdict();
      end
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge core_clk_i);
   endtask : apb
   task automatic edge_to(input logic v, input logic fire);
      if (fire) exp_q.push_back(info);
      trigger_i <= v;
      repeat (8) @(posedge core_clk_i);
      chk(32'(exp_q.size()), 32'h0);
   endtask : edge_to
   always @(negedge core_clk_i) begin
      if (rst_n_i === 1'b1 && host_irq_o === 1'b1) begin
         if (exp_q.size() == 0) chk(32'h1, 32'h0);
         else chk(supplementary_info_word_o, exp_q.pop_front());
      end
   end
   initial begin
      repeat (19) @(posedge core_clk_i);
      chk_bit(host_irq_o, 1'b0);
      chk_bit(error_flag_out_o, 1'b0);
      @(posedge core_clk_i);
      rst_n_i <= 1'b1;
      @(posedge core_clk_i);
      info = $random(seed);
      apb(1'b1, 12'h008, info);
      apb(1'b0, 12'h008, 32'h0);
      chk(q, info);
      apb(1'b0, 12'h100, 32'h0);
      chk(q, 32'h0);
      chk_bit(e, 1'b1);
      edge_to(1'b1, 1'b1);
      edge_to(1'b0, 1'b0);
      apb(1'b1, 12'h000, 32'h1);
      edge_to(1'b1, 1'b1);
      edge_to(1'b0, 1'b1);
      lat <= 5'h14;
      edge_to(1'b1, 1'b1);
      edge_to(1'b0, 1'b0);
      chk_bit(error_flag_out_o, 1'b1);
      repeat (12) @(posedge core_clk_i);
      chk_bit(error_flag_out_o, 1'b0);
      edge_to(1'b1, 1'b1);
      edge_to(1'b0, 1'b0);
      apb(1'b1, 12'h000, 32'h3);
      repeat (3) @(posedge core_clk_i);
      chk_bit(error_flag_out_o, 1'b0);
      apb(1'b1, 12'h000, 32'h1);
      repeat (20) @(posedge core_clk_i);
      platform_valid_i <= 1'b0;
      repeat (8) @(posedge core_clk_i);
      edge_to(1'b1, 1'b0);
      chk_bit(error_flag_out_o, 1'b1);
      rst_n_i <= 1'b0;
      platform_valid_i <= 1'b1;
      trigger_i <= 1'b0;
      repeat (2) @(posedge core_clk_i);
      chk_bit(host_irq_o, 1'b0);
      chk_bit(error_flag_out_o, 1'b0);
      rst_n_i <= 1'b1;
      repeat (4) @(posedge core_clk_i);
      chk_bit(error_flag_out_o, 1'b0);
      give_verdict();
   end
endmodule : tb_top

// [verilog/hpit_apb.sv]
// apb slave holding control and info registers
`timescale 1ns/10ps
`include "hpit_map.svh"
module hpit_apb
   import hpit_pkg::*;
(
   // clock and reset
   input  wire logic        core_clk_i,
   input  wire logic        rst_n_i,
   // apb
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // block state
   input  wire logic [2:0]  status_i,
   input  wire logic [31:0] count_i,
   output logic             both_edges_o,
   output logic             clear_error_o,
   output hpit_word_t       info_o
);
   logic [1:0]  ctrl_ff;
   logic [1:0]  nxt_ctrl;
   hpit_word_t  info_ff;
   hpit_word_t  nxt_info;
   logic [31:0] rdata_ff;
   logic [31:0] nxt_rdata;
   logic        err_ff;
   logic        nxt_err;
   logic        setup;
   logic        wr_access;
   logic        hit;

   always_comb begin
      setup     = psel && !penable;
      wr_access = psel && penable && pwrite;
      hit       = (paddr == `HPIT_CTRL_OFS) || (paddr == `HPIT_STAT_OFS)
                  || (paddr == `HPIT_INFO_OFS) || (paddr == `HPIT_CNT_OFS);
      nxt_ctrl  = ctrl_ff;
      nxt_info  = info_ff;
      nxt_rdata = rdata_ff;
      nxt_err   = err_ff;
      if (setup) begin
         nxt_err   = !hit;
         nxt_rdata = 32'h0000_0000;
         if (!pwrite) begin
            case (paddr)
               `HPIT_CTRL_OFS: nxt_rdata = {30'h0, ctrl_ff};
               `HPIT_STAT_OFS: nxt_rdata = {29'h0, status_i};
               `HPIT_INFO_OFS: nxt_rdata = info_ff;
               `HPIT_CNT_OFS:  nxt_rdata = count_i;
               default:        nxt_rdata = 32'h0000_0000;
            endcase
         end
      end
      // writes take effect at the access edge only
      if (wr_access) begin
         case (paddr)
            `HPIT_CTRL_OFS: nxt_ctrl = pwdata[1:0];
            `HPIT_INFO_OFS: nxt_info = pwdata;
            default:        nxt_ctrl = ctrl_ff;
         endcase
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ctrl_ff  <= `HPIT_CTRL_RST;
         info_ff  <= `HPIT_INFO_RST;
         rdata_ff <= 32'h0000_0000;
         err_ff   <= 1'b0;
      end else begin
         ctrl_ff  <= nxt_ctrl;
         info_ff  <= nxt_info;
         rdata_ff <= nxt_rdata;
         err_ff   <= nxt_err;
      end
   end

   assign pready        = psel && penable;
   assign prdata        = rdata_ff;
   assign pslverr       = psel && penable && err_ff;
   assign both_edges_o  = ctrl_ff[`HPIT_CTRL_BOTH];
   assign clear_error_o = ctrl_ff[`HPIT_CTRL_CLR];
   assign info_o        = info_ff;
endmodule : hpit_apb

// [verilog/hpit_sync.sv]
// two flip-flop synchroniser for pin inputs
`timescale 1ns/10ps
module hpit_sync #(
   parameter int W = 1
) (
   input  wire logic         core_clk_i,
   input  wire logic         rst_n_i,
   input  wire logic [W-1:0] d_i,
   output logic      [W-1:0] q_o
);
   logic [W-1:0] meta_ff;
   logic [W-1:0] nxt_meta;
   logic [W-1:0] q_ff;
   logic [W-1:0] nxt_q;

   always_comb begin
      nxt_meta = d_i;
      nxt_q    = meta_ff;
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         meta_ff <= '0;
         q_ff    <= '0;
      end else begin
         meta_ff <= nxt_meta;
         q_ff    <= nxt_q;
      end
   end

   assign q_o = q_ff;
endmodule : hpit_sync

// [verilog/hpit_top.sv]
// host process interrupt trigger: edge detect, request, pending and error
//
// Design decisions made here: the APB register port and the address map.
`timescale 1ns/10ps
`include "hpit_map.svh"
module hpit_top
   import hpit_pkg::*;
(
   // clock and reset
   input  wire logic        core_clk_i,
   input  wire logic        rst_n_i,
   // apb
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // pins
   input  wire logic        trigger_i,
   input  wire logic        platform_valid_i,
   // host interrupt path
   input  wire logic        host_ack_i,
   output logic             host_irq_o,
   output logic      [31:0] supplementary_info_word_o,
   output logic             error_flag_out_o
);
   logic [1:0]  pins_s;
   logic        both_edges_select;
   logic        clear_error_in;
   hpit_word_t  info_reg;
   logic        trig_prev_ff;
   logic        nxt_trig_prev;
   hpit_state_e state_ff;
   hpit_state_e nxt_state;
   logic        err_ff;
   logic        nxt_err;
   logic        irq_ff;
   logic        nxt_irq;
   hpit_word_t  info_ff;
   hpit_word_t  nxt_info;
   logic [31:0] cnt_ff;
   logic [31:0] nxt_cnt;
   logic        event_hit;
   logic        pending;
   logic [1:0]  warm_ff;
   logic [1:0]  nxt_warm;
   logic        plat_ok;

   // ------------------------------------------------------------------
   // input synchronisation
   // ------------------------------------------------------------------
   hpit_sync #(.W(2)) u_sync (
      .core_clk_i (core_clk_i),
      .rst_n_i    (rst_n_i),
      .d_i        ({platform_valid_i, trigger_i}),
      .q_o        (pins_s)
   );

   // ------------------------------------------------------------------
   // registers
   // ------------------------------------------------------------------
   hpit_apb u_apb (
      .core_clk_i    (core_clk_i),
      .rst_n_i       (rst_n_i),
      .psel          (psel),
      .penable       (penable),
      .pwrite        (pwrite),
      .paddr         (paddr),
      .pwdata        (pwdata),
      .prdata        (prdata),
      .pready        (pready),
      .pslverr       (pslverr),
      .status_i      ({pins_s[1], err_ff, pending}),
      .count_i       (cnt_ff),
      .both_edges_o  (both_edges_select),
      .clear_error_o (clear_error_in),
      .info_o        (info_reg)
   );

   // ------------------------------------------------------------------
   // trigger and request logic
   // ------------------------------------------------------------------
   assign pending = (state_ff == HPIT_PEND);

   always_comb begin
      nxt_trig_prev = pins_s[0]; // R11
      // sync stages hold reset zeros for two edges; ignore platform pin until filled
      nxt_warm      = {warm_ff[0], 1'b1};
      plat_ok       = pins_s[1] || !warm_ff[1];
      event_hit     = both_edges_select ? (pins_s[0] != trig_prev_ff) // R4
                                        : (pins_s[0] && !trig_prev_ff); // R3
      nxt_state     = state_ff;
      nxt_err       = err_ff;
      nxt_irq       = 1'b0;
      nxt_info      = info_ff;
      nxt_cnt       = cnt_ff;
      case (state_ff)
         HPIT_IDLE: begin
            if (event_hit && plat_ok) begin
               nxt_irq   = 1'b1; // R1
               nxt_info  = info_reg; // R2
               nxt_state = HPIT_PEND; // R8
               nxt_cnt   = cnt_ff + 32'h0000_0001;
            end
         end
         HPIT_PEND: begin
            if (host_ack_i) begin
               nxt_state = HPIT_IDLE; // R8
               nxt_err   = 1'b0; // R7
            end
            if (event_hit) begin
               nxt_err = 1'b1; // R5 R6
            end
         end
         default: nxt_state = HPIT_IDLE;
      endcase
      if (clear_error_in) begin
         nxt_err = 1'b0; // R7
      end
      if (!plat_ok) begin
         nxt_err = 1'b1; // R10
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         trig_prev_ff <= 1'b0; // R11
         warm_ff      <= 2'h0;
         state_ff     <= HPIT_IDLE;
         err_ff       <= 1'b0;
         irq_ff       <= 1'b0;
         info_ff      <= 32'h0000_0000;
         cnt_ff       <= 32'h0000_0000;
      end else begin
         trig_prev_ff <= nxt_trig_prev;
         warm_ff      <= nxt_warm;
         state_ff     <= nxt_state;
         err_ff       <= nxt_err;
         irq_ff       <= nxt_irq;
         info_ff      <= nxt_info;
         cnt_ff       <= nxt_cnt;
      end
   end

   assign host_irq_o                = irq_ff;
   assign supplementary_info_word_o = info_ff;
   assign error_flag_out_o          = err_ff;
endmodule : hpit_top
